// *** pio_board.sv ***
// Board model: resolves each shared pin from the block's enables and the board drivers.
// Assumes pins packed as port d, c, b, a from the top; the board drives released pins.
module pio_board (
   input  wire logic [29:0] pin_out,
   input  wire logic [29:0] pin_oe_n,
   input  wire logic [29:0] board_drv,
   output wire logic [29:0] pin_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   // A pin follows the block when its enable is low, else the board level.
   assign pin_lvl = (pin_out & ~pin_oe_n) | (board_drv & pin_oe_n);
endmodule // pio_board

// *** pio_consts.vh ***
// Constants for the parallel port block: register indices, field positions, reset values.
// Assumes inclusion by the port block and by verification code that needs the map.
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// ==========================================================================
// Register indices; the byte address is four times the index.
// ==========================================================================
`define PIO_IDX_W            6
`define PIO_IDX_PORT_A_DATA  6'h00
`define PIO_IDX_PORT_B_DATA  6'h01
`define PIO_IDX_PORT_C_DATA  6'h02
`define PIO_IDX_PORT_D_DATA  6'h03
`define PIO_IDX_PORT_A_DIR   6'h04
`define PIO_IDX_PORT_B_DIR   6'h05
`define PIO_IDX_PORT_C_DIR   6'h06
`define PIO_IDX_PORT_D_DIR   6'h07
`define PIO_IDX_AOUT_SEL_LO  6'h39
`define PIO_IDX_AOUT_SEL_HI  6'h3a

// ==========================================================================
// Address fields of the bus.
// ==========================================================================
`define PIO_ADDR_IDX_HI      7
`define PIO_ADDR_IDX_LO      2
`define PIO_ADDR_TOP_HI      31
`define PIO_ADDR_TOP_LO      8
`define PIO_ADDR_TOP_ZERO    24'h000000

// ==========================================================================
// Field positions and fixed values.
// ==========================================================================
`define PIO_C_INPUT_ONLY_BIT 2
`define PIO_C_COMPARE_BIT    5
`define PIO_C_CAPTURE_BIT    4
`define PIO_C_DA8_BIT        0
`define PIO_AOUT_HI_BIT      0
`define PIO_DIR_RESET8       8'h00
`define PIO_DIR_RESET6       6'h00
`define PIO_SEL_RESET8       8'h00
`define PIO_SEL_RESET1       1'h0
`define PIO_C_IMPL_MASK      6'h3f
`define PIO_C_DIR_MASK       6'h3b
`define PIO_C_DIR_ONE        6'h04
`define PIO_C_ADC_MASK       6'h07
`define PIO_D_SERIAL_MASK    8'h06
`define PIO_D_OVERLAY_MASK   8'hf8
`define PIO_HTRANS_NONSEQ    1
`define PIO_RESP_OKAY        1'h0
`define PIO_ZERO32           32'h00000000
`define PIO_ZERO24           24'h000000

`endif

// *** pio_monitor.sv ***
// Checker for the parallel port block: pin ownership, read fields and synchronisers.
// Assumes one clock hclk and the asynchronous active-low reset hresetn.
module pio_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic [7:0]  port_a_pin_oe_n,
   input wire logic [5:0]  port_c_pin_in,
   input wire logic [5:0]  port_c_pin_out,
   input wire logic [5:0]  port_c_pin_oe_n,
   input wire logic [7:0]  port_d_pin_in,
   input wire logic [7:0]  port_d_pin_out,
   input wire logic [7:0]  port_d_pin_oe_n,
   input wire logic        compare_pin_enable,
   input wire logic        timer_compare_output,
   input wire logic        timer_irq_enabled,
   input wire logic        timer_capture_input,
   input wire logic        analog_converter_enabled,
   input wire logic        sync_serial_port_enabled,
   input wire logic [1:0]  sync_serial_pin_out,
   input wire logic [1:0]  sync_serial_pin_oe_n,
   input wire logic [1:0]  sync_serial_pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================================================
   // Helper logic.
   // ======================================================================
   logic [1:0] up_cnt_reg;
   wire        rd_req = hsel && htrans[1] && hready && !hwrite;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) up_cnt_reg <= 2'h0;
      else if (up_cnt_reg != 2'h3) up_cnt_reg <= up_cnt_reg + 2'h1;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ======================================================================
   // Properties.
   // ======================================================================
   property p_c_input_only; port_c_pin_oe_n[2] == 1'b1; endproperty
   a_c_input_only: assert property (p_c_input_only) else $error("input-only pin driven");
   property p_dir_c_one; rd_req && haddr == 32'h18 |=> hrdata[2] == 1'b1; endproperty
   a_dir_c_one: assert property (p_dir_c_one) else $error("dir c bit 2 not one");
   property p_c_top_zero; rd_req && (haddr == 32'h08 || haddr == 32'h18) |=> hrdata[7:6] == 2'h0;
   endproperty
   a_c_top_zero: assert property (p_c_top_zero) else $error("port c top bits set");
   property p_sel_hi; rd_req && haddr == 32'he8 |=> hrdata[7:1] == 7'h00; endproperty
   a_sel_hi: assert property (p_sel_hi) else $error("route high spare bits set");
   property p_compare; compare_pin_enable |->
      !port_c_pin_oe_n[5] && port_c_pin_out[5] == timer_compare_output; endproperty
   a_compare: assert property (p_compare) else $error("compare pin not driven");
   property p_capture_own; timer_irq_enabled |-> port_c_pin_oe_n[4]; endproperty
   a_capture_own: assert property (p_capture_own) else $error("capture pin driven");
   property p_adc; analog_converter_enabled |-> port_c_pin_oe_n[2:1] == 2'h3; endproperty
   a_adc: assert property (p_adc) else $error("converter pins driven");
   property p_serial; sync_serial_port_enabled |-> port_d_pin_out[2:1] == sync_serial_pin_out
      && port_d_pin_oe_n[2:1] == sync_serial_pin_oe_n; endproperty
   a_serial: assert property (p_serial) else $error("serial pins not passed");
   property p_reset_in; $rose(hresetn) |-> port_a_pin_oe_n == 8'hff [*2]; endproperty
   a_reset_in: assert property (p_reset_in) else $error("port a not input after reset");
   property p_cap_sync; up_cnt_reg == 2'h3 |-> timer_capture_input == $past(port_c_pin_in[4], 2);
   endproperty
   a_cap_sync: assert property (p_cap_sync) else $error("capture level wrong");
   property p_ser_sync; up_cnt_reg == 2'h3 |->
      sync_serial_pin_level == $past(port_d_pin_in[2:1], 2); endproperty
   a_ser_sync: assert property (p_ser_sync) else $error("serial level wrong");
endmodule // pio_monitor

bind pio_ports pio_monitor mon_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hrdata, .port_a_pin_oe_n, .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe_n, .port_d_pin_in,
   .port_d_pin_out, .port_d_pin_oe_n, .compare_pin_enable, .timer_compare_output,
   .timer_irq_enabled, .timer_capture_input, .analog_converter_enabled,
   .sync_serial_port_enabled, .sync_serial_pin_out, .sync_serial_pin_oe_n, .sync_serial_pin_level);

// *** pio_ports.v ***
// Four memory-mapped parallel ports with pin sharing, reached over AHB-Lite.
// Assumes hclk at 100 MHz, one bus master, pins resolved by the bench from the enables.

`include "pio_consts.vh"

module pio_ports (
   hclk,
   hresetn,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp,
   port_a_pin_in,
   port_a_pin_out,
   port_a_pin_oe_n,
   port_b_pin_in,
   port_b_pin_out,
   port_b_pin_oe_n,
   port_c_pin_in,
   port_c_pin_out,
   port_c_pin_oe_n,
   port_d_pin_in,
   port_d_pin_out,
   port_d_pin_oe_n,
   analog_out_level,
   compare_pin_enable,
   timer_compare_output,
   timer_irq_enabled,
   timer_capture_input,
   analog_converter_enabled,
   sync_serial_port_enabled,
   sync_serial_pin_out,
   sync_serial_pin_oe_n,
   sync_serial_pin_level,
   screen_overlay_enabled,
   screen_overlay_pin_out,
   screen_overlay_pin_oe_n
);

   input  wire        hclk;
   input  wire        hresetn;
   input  wire        hsel;
   input  wire [31:0] haddr;
   input  wire [1:0]  htrans;
   input  wire        hwrite;
   input  wire [2:0]  hsize;
   input  wire [31:0] hwdata;
   input  wire        hready;
   output wire [31:0] hrdata;
   output wire        hreadyout;
   output wire        hresp;
   input  wire [7:0]  port_a_pin_in;
   output wire [7:0]  port_a_pin_out;
   output wire [7:0]  port_a_pin_oe_n;
   input  wire [7:0]  port_b_pin_in;
   output wire [7:0]  port_b_pin_out;
   output wire [7:0]  port_b_pin_oe_n;
   input  wire [5:0]  port_c_pin_in;
   output wire [5:0]  port_c_pin_out;
   output wire [5:0]  port_c_pin_oe_n;
   input  wire [7:0]  port_d_pin_in;
   output wire [7:0]  port_d_pin_out;
   output wire [7:0]  port_d_pin_oe_n;
   input  wire [8:0]  analog_out_level;
   input  wire        compare_pin_enable;
   input  wire        timer_compare_output;
   input  wire        timer_irq_enabled;
   output wire        timer_capture_input;
   input  wire        analog_converter_enabled;
   input  wire        sync_serial_port_enabled;
   input  wire [1:0]  sync_serial_pin_out;
   input  wire [1:0]  sync_serial_pin_oe_n;
   output wire [1:0]  sync_serial_pin_level;
   input  wire        screen_overlay_enabled;
   input  wire [4:0]  screen_overlay_pin_out;
   input  wire [4:0]  screen_overlay_pin_oe_n;

   // ==========================================================================
   // Read selection between latch and pin.
   // ==========================================================================
   function [7:0] pio_pick;
      input [7:0] dir;
      input [7:0] latch;
      input [7:0] pin;
      begin
         pio_pick = (dir & latch) | (~dir & pin);
      end
   endfunction

   // ==========================================================================
   // Registers.
   // ==========================================================================
   reg  [7:0]  port_a_data_reg;
   reg  [7:0]  port_b_data_reg;
   reg  [5:0]  port_c_data_reg;
   reg  [7:0]  port_d_data_reg;
   reg  [7:0]  port_a_direction_reg;
   reg  [7:0]  port_b_direction_reg;
   reg  [5:0]  port_c_direction_reg;
   reg  [7:0]  port_d_direction_reg;
   reg  [7:0]  analog_out_pin_select_low_reg;
   reg         analog_out_pin_select_high_reg;
   reg  [7:0]  port_a_data_next;
   reg  [7:0]  port_b_data_next;
   reg  [5:0]  port_c_data_next;
   reg  [7:0]  port_d_data_next;
   reg  [7:0]  port_a_direction_next;
   reg  [7:0]  port_b_direction_next;
   reg  [5:0]  port_c_direction_next;
   reg  [7:0]  port_d_direction_next;
   reg  [7:0]  analog_out_pin_select_low_next;
   reg         analog_out_pin_select_high_next;
   reg         wr_pending_reg;
   reg  [5:0]  wr_index_reg;
   reg  [31:0] hrdata_reg;
   reg  [31:0] hrdata_next;
   reg  [29:0] pin_meta_reg;
   reg  [29:0] pin_sync_reg;

   wire        addr_phase;
   wire        addr_mapped_top;
   wire [5:0]  addr_index;
   wire [7:0]  wdata;
   wire [7:0]  pin_a;
   wire [7:0]  pin_b;
   wire [5:0]  pin_c;
   wire [7:0]  pin_d;
   wire [8:0]  route;
   wire [7:0]  own_b;
   wire [5:0]  own_c;
   wire [7:0]  own_d;
   wire [5:0]  dir_c_eff;
   wire [5:0]  c_adc_mask;

   // ==========================================================================
   // Pin synchronisers.
   // ==========================================================================
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta_reg <= 30'h00000000;
         pin_sync_reg <= 30'h00000000;
      end else begin
         pin_meta_reg <= {port_d_pin_in, port_c_pin_in, port_b_pin_in, port_a_pin_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign pin_a = pin_sync_reg[7:0];
   assign pin_b = pin_sync_reg[15:8];
   assign pin_c = pin_sync_reg[21:16];
   assign pin_d = pin_sync_reg[29:22];

   // ==========================================================================
   // Bus decode.
   // ==========================================================================
   assign addr_phase = hsel & htrans[`PIO_HTRANS_NONSEQ] & hready;
   assign addr_mapped_top = (haddr[`PIO_ADDR_TOP_HI:`PIO_ADDR_TOP_LO] == `PIO_ADDR_TOP_ZERO);
   assign addr_index = haddr[`PIO_ADDR_IDX_HI:`PIO_ADDR_IDX_LO];
   assign wdata = hwdata[7:0];
   assign hreadyout = 1'b1;
   assign hresp = `PIO_RESP_OKAY;
   assign hrdata = hrdata_reg;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending_reg <= 1'b0;
         wr_index_reg <= 6'h00;
      end else begin
         wr_pending_reg <= addr_phase & hwrite & addr_mapped_top;
         wr_index_reg <= addr_index;
      end
   end

   // ==========================================================================
   // Register write logic.
   // ==========================================================================
   always @* begin
      port_a_data_next = port_a_data_reg;
      port_b_data_next = port_b_data_reg;
      port_c_data_next = port_c_data_reg;
      port_d_data_next = port_d_data_reg;
      port_a_direction_next = port_a_direction_reg;
      port_b_direction_next = port_b_direction_reg;
      port_c_direction_next = port_c_direction_reg;
      port_d_direction_next = port_d_direction_reg;
      analog_out_pin_select_low_next = analog_out_pin_select_low_reg;
      analog_out_pin_select_high_next = analog_out_pin_select_high_reg;
      if (wr_pending_reg) begin
         case (wr_index_reg)
            `PIO_IDX_PORT_A_DATA: port_a_data_next = wdata;
            `PIO_IDX_PORT_B_DATA: port_b_data_next = wdata;
            `PIO_IDX_PORT_C_DATA: port_c_data_next = wdata[5:0] & `PIO_C_IMPL_MASK;
            `PIO_IDX_PORT_D_DATA: port_d_data_next = wdata;
            `PIO_IDX_PORT_A_DIR: port_a_direction_next = wdata;
            `PIO_IDX_PORT_B_DIR: port_b_direction_next = wdata;
            `PIO_IDX_PORT_C_DIR: port_c_direction_next = wdata[5:0] & `PIO_C_DIR_MASK;
            `PIO_IDX_PORT_D_DIR: port_d_direction_next = wdata;
            `PIO_IDX_AOUT_SEL_LO: analog_out_pin_select_low_next = wdata;
            `PIO_IDX_AOUT_SEL_HI: analog_out_pin_select_high_next = wdata[`PIO_AOUT_HI_BIT];
            default: port_a_data_next = port_a_data_reg;
         endcase
      end
   end

   // Data latches carry no reset.
   always @(posedge hclk) begin
      port_a_data_reg <= port_a_data_next;
      port_b_data_reg <= port_b_data_next;
      port_c_data_reg <= port_c_data_next;
      port_d_data_reg <= port_d_data_next;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_a_direction_reg <= `PIO_DIR_RESET8;
         port_b_direction_reg <= `PIO_DIR_RESET8;
         port_c_direction_reg <= `PIO_DIR_RESET6;
         port_d_direction_reg <= `PIO_DIR_RESET8;
         analog_out_pin_select_low_reg <= `PIO_SEL_RESET8;
         analog_out_pin_select_high_reg <= `PIO_SEL_RESET1;
      end else begin
         port_a_direction_reg <= port_a_direction_next;
         port_b_direction_reg <= port_b_direction_next;
         port_c_direction_reg <= port_c_direction_next;
         port_d_direction_reg <= port_d_direction_next;
         analog_out_pin_select_low_reg <= analog_out_pin_select_low_next;
         analog_out_pin_select_high_reg <= analog_out_pin_select_high_next;
      end
   end

   // ==========================================================================
   // Register read logic, using next values so a write just before is seen.
   // ==========================================================================
   assign dir_c_eff = port_c_direction_next & `PIO_C_DIR_MASK;

   always @* begin
      hrdata_next = `PIO_ZERO32;
      if (addr_phase & ~hwrite & addr_mapped_top) begin
         case (addr_index)
            `PIO_IDX_PORT_A_DATA:
               hrdata_next = {`PIO_ZERO24,
                  pio_pick(port_a_direction_next, port_a_data_next, pin_a)};
            `PIO_IDX_PORT_B_DATA:
               hrdata_next = {`PIO_ZERO24,
                  pio_pick(port_b_direction_next, port_b_data_next, pin_b)};
            `PIO_IDX_PORT_C_DATA:
               hrdata_next = {`PIO_ZERO24, pio_pick({2'b00, dir_c_eff},
                  {2'b00, port_c_data_next}, {2'b00, pin_c})};
            `PIO_IDX_PORT_D_DATA:
               hrdata_next = {`PIO_ZERO24,
                  pio_pick(port_d_direction_next, port_d_data_next, pin_d)};
            `PIO_IDX_PORT_A_DIR:
               hrdata_next = {`PIO_ZERO24, port_a_direction_next};
            `PIO_IDX_PORT_B_DIR:
               hrdata_next = {`PIO_ZERO24, port_b_direction_next};
            `PIO_IDX_PORT_C_DIR:
               hrdata_next = {`PIO_ZERO24, 2'b00, dir_c_eff | `PIO_C_DIR_ONE};
            `PIO_IDX_PORT_D_DIR:
               hrdata_next = {`PIO_ZERO24, port_d_direction_next};
            `PIO_IDX_AOUT_SEL_LO:
               hrdata_next = {`PIO_ZERO24, analog_out_pin_select_low_next};
            `PIO_IDX_AOUT_SEL_HI:
               hrdata_next = {`PIO_ZERO24, 7'h00, analog_out_pin_select_high_next};
            default:
               hrdata_next = `PIO_ZERO32;
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= `PIO_ZERO32;
      end else if (addr_phase & ~hwrite) begin
         hrdata_reg <= hrdata_next;
      end
   end

   // ==========================================================================
   // Pin ownership by alternate functions.
   // ==========================================================================
   assign route = {analog_out_pin_select_high_reg, analog_out_pin_select_low_reg};
   assign own_b = route[7:0];
   assign c_adc_mask = analog_converter_enabled ? `PIO_C_ADC_MASK : 6'h00;
   assign own_c = {compare_pin_enable, timer_irq_enabled, 1'b0, 3'b000}
                | c_adc_mask
                | {5'h00, route[8]};
   assign own_d = (sync_serial_port_enabled ? `PIO_D_SERIAL_MASK : 8'h00)
                | (screen_overlay_enabled ? `PIO_D_OVERLAY_MASK : 8'h00);

   // ==========================================================================
   // Port A drive.
   // ==========================================================================
   assign port_a_pin_out = port_a_data_reg;
   assign port_a_pin_oe_n = ~port_a_direction_reg;

   // ==========================================================================
   // Port B drive, analog outputs take over routed pins.
   // ==========================================================================
   assign port_b_pin_out = (own_b & analog_out_level[7:0])
                         | (~own_b & port_b_data_reg);
   // Routed pins drive the analog output; others follow direction.
   assign port_b_pin_oe_n = ~(own_b | port_b_direction_reg);

   // ==========================================================================
   // Port C drive.
   // ==========================================================================
   assign port_c_pin_out[5] = compare_pin_enable ? timer_compare_output
                            : port_c_data_reg[5];
   assign port_c_pin_out[4:1] = port_c_data_reg[4:1];
   assign port_c_pin_out[0] = route[8] ? analog_out_level[8] : port_c_data_reg[0];
   assign port_c_pin_oe_n[5] = compare_pin_enable ? 1'b0
                             : ~port_c_direction_reg[5];
   assign port_c_pin_oe_n[4:3] = ~(port_c_direction_reg[4:3] & ~own_c[4:3]);
   assign port_c_pin_oe_n[2] = 1'b1;
   assign port_c_pin_oe_n[1] = ~(port_c_direction_reg[1] & ~own_c[1]);
   assign port_c_pin_oe_n[0] = route[8] ? 1'b0
                             : ~(port_c_direction_reg[0] & ~own_c[0]);
   assign timer_capture_input = pin_c[`PIO_C_CAPTURE_BIT];

   // ==========================================================================
   // Port D drive.
   // ==========================================================================
   assign port_d_pin_out[7:3] = screen_overlay_enabled ? screen_overlay_pin_out
                              : port_d_data_reg[7:3];
   assign port_d_pin_out[2:1] = sync_serial_port_enabled ? sync_serial_pin_out
                              : port_d_data_reg[2:1];
   assign port_d_pin_out[0] = port_d_data_reg[0];
   assign port_d_pin_oe_n[7:3] = own_d[3] ? screen_overlay_pin_oe_n
                               : ~port_d_direction_reg[7:3];
   assign port_d_pin_oe_n[2:1] = own_d[1] ? sync_serial_pin_oe_n
                               : ~port_d_direction_reg[2:1];
   assign port_d_pin_oe_n[0] = ~port_d_direction_reg[0];
   assign sync_serial_pin_level = pin_d[2:1];

endmodule // pio_ports

// *** tb_top.sv ***
// Testbench for the parallel port block: bus tasks and directed checks.
// Assumes the block answers without wait states and the board model resolves the pins.
`include "pio_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0]  htrans = 2'h0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, cap_in;
   wire  [7:0]  a_out, a_oe_n, b_out, b_oe_n, d_out, d_oe_n;
   wire  [5:0]  c_out, c_oe_n;
   wire  [1:0]  ser_lvl;
   wire  [29:0] lvl;
   logic [7:0]  dv[4] = '{8'ha5, 8'h96, 8'hff, 8'h4b};
   logic [7:0]  bv[4] = '{8'h3c, 8'hc6, 8'h3d, 8'h71};
   logic [7:0]  im, d;
   logic        cmp_en = 1'b0, cmp_out = 1'b0, tirq = 1'b0, adc_en = 1'b0;
   logic        ser_en = 1'b0, ovl_en = 1'b0;
   logic [8:0]  aol = 9'h1a5;
   int          fail_count = 0, samples_checked = 0;
   wire  [29:0] drv = {bv[3], bv[2][5:0], bv[1], bv[0]};
   always #5 hclk = ~hclk;
   pio_ports dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .port_a_pin_in(lvl[7:0]), .port_a_pin_out(a_out),
      .port_a_pin_oe_n(a_oe_n), .port_b_pin_in(lvl[15:8]), .port_b_pin_out(b_out),
      .port_b_pin_oe_n(b_oe_n), .port_c_pin_in(lvl[21:16]), .port_c_pin_out(c_out),
      .port_c_pin_oe_n(c_oe_n), .port_d_pin_in(lvl[29:22]), .port_d_pin_out(d_out),
      .port_d_pin_oe_n(d_oe_n), .analog_out_level(aol), .compare_pin_enable(cmp_en),
      .timer_compare_output(cmp_out), .timer_irq_enabled(tirq), .timer_capture_input(cap_in),
      .analog_converter_enabled(adc_en), .sync_serial_port_enabled(ser_en),
      .sync_serial_pin_out(2'h1), .sync_serial_pin_oe_n(2'h2), .sync_serial_pin_level(ser_lvl),
      .screen_overlay_enabled(ovl_en), .screen_overlay_pin_out(5'h15),
      .screen_overlay_pin_oe_n(5'h0a));
   pio_board board_u (.pin_out({d_out, c_out, b_out, a_out}),
      .pin_oe_n({d_oe_n, c_oe_n, b_oe_n, a_oe_n}), .board_drv(drv), .pin_lvl(lvl));
   // ======================================================================
   // Tasks.
   // ======================================================================
   task results;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 100) begin
         n++;
         @(posedge hclk);
      end
      if (n >= 100) begin
         fail_count++;
         $display("BAD %0t bus hang", $time);
         results;
      end
   endtask
   task bus(input logic wr, input logic [5:0] ix, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, ix, 2'h0};
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_ready;
      rd = hrdata;
   endtask
   task rchk(input logic [5:0] ix, input logic [7:0] exp);
      bus(1'b0, ix, 8'h00);
      chk(rd, {24'h0, exp});
   endtask
   task settle;
      @(posedge hclk);
      #1;
   endtask
   // ======================================================================
   // Main sequence.
   // ======================================================================
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int p = 0; p < 4; p++) begin
         im = (p == 2) ? 8'h3f : 8'hff;
         d = (p == 2) ? 8'h1a : 8'hda;
         rchk(6'(p + 4), (p == 2) ? 8'h04 : 8'h00);
         bus(1'b1, 6'(p), dv[p]);
         repeat (4) @(posedge hclk);
         rchk(6'(p), bv[p] & im);
         bus(1'b1, 6'(p + 4), 8'hda);
         repeat (4) @(posedge hclk);
         rchk(6'(p + 4), (p == 2) ? 8'h1e : 8'hda);
         rchk(6'(p), ((dv[p] & d) | (bv[p] & ~d)) & im);
      end
      settle;
      chk({a_oe_n, b_oe_n, d_oe_n, 2'h0, c_oe_n}, 32'h25252525);
      chk(a_out, 8'ha5);
      hresetn <= 1'b0;
      settle;
      chk({a_oe_n, b_oe_n, d_oe_n, 2'h0, c_oe_n}, 32'hffffff3f);
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(`PIO_IDX_PORT_A_DIR, 8'h00);
      bus(1'b1, `PIO_IDX_PORT_A_DIR, 8'hff);
      rchk(`PIO_IDX_PORT_A_DATA, 8'ha5);
      bus(1'b1, 6'h20, 8'hff);
      rchk(6'h20, 8'h00);
      rchk(`PIO_IDX_AOUT_SEL_LO, 8'h00);
      bus(1'b1, `PIO_IDX_AOUT_SEL_LO, 8'hff);
      bus(1'b1, `PIO_IDX_AOUT_SEL_HI, 8'hff);
      rchk(`PIO_IDX_AOUT_SEL_LO, 8'hff);
      rchk(`PIO_IDX_AOUT_SEL_HI, 8'h01);
      settle;
      chk({b_out, b_oe_n, 7'h0, c_out[0], 7'h0, c_oe_n[0]}, 32'ha5000100);
      aol <= 9'h05a;
      settle;
      chk({b_out, 7'h0, c_out[0]}, 16'h5a00);
      bus(1'b1, `PIO_IDX_AOUT_SEL_LO, 8'h00);
      bus(1'b1, `PIO_IDX_AOUT_SEL_HI, 8'h00);
      bus(1'b1, `PIO_IDX_PORT_C_DIR, 8'h3b);
      settle;
      chk({b_oe_n, 2'h0, c_oe_n}, 16'hff04);
      cmp_en <= 1'b1;
      cmp_out <= 1'b1;
      tirq <= 1'b1;
      adc_en <= 1'b1;
      ser_en <= 1'b1;
      ovl_en <= 1'b1;
      settle;
      chk({c_out[5], c_oe_n}, 7'h57);
      chk({d_out, d_oe_n}, 16'hab55);
      repeat (4) @(posedge hclk);
      chk({cap_in, ser_lvl}, 3'h5);
      cmp_en <= 1'b0;
      tirq <= 1'b0;
      adc_en <= 1'b0;
      settle;
      chk(c_oe_n, 6'h04);
      results;
   end
endmodule // tb_top
